/* pdm_pkg.sv */
// package for the power-down mode controller
package pdm_pkg;
	localparam int PDM_DEPTH_BIT = 2;
	localparam logic [7:0] PDM_CTRL_RESET = 8'h00;
	localparam int PDM_CLK_MHZ = 100;
	localparam int PDM_WARMUP_NS = 2000;
	localparam int PDM_WARMUP_CYC = (PDM_WARMUP_NS * PDM_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] PDM_WARMUP_CNT = 8'(PDM_WARMUP_CYC);

	typedef enum logic [1:0] {
		PDM_RUN,
		PDM_LIGHT,
		PDM_DEEP,
		PDM_HALT
	} pdm_state_t;

	// clock gating enables toward the rest of the chip
	typedef struct packed {
		logic cpu_run;
		logic core_clock;
		logic rc_osc;
		logic xtal_osc;
		logic event_timer_one;
		logic tone_generator_unit;
	} pdm_gates_t;

	// wake request toward the core
	typedef struct packed {
		logic resume;
		logic take_vector;
	} pdm_wake_t;
endpackage

/* pdm_warmup.sv */
// oscillator warm-up counter
`timescale 1ns/100ps
module pdm_warmup (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic start_i,
	output logic busy_o
);
	import pdm_pkg::*;
	logic [7:0] cnt_q;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_q <= 8'h00;
		end else if (start_i) begin
			cnt_q <= PDM_WARMUP_CNT;
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end

	assign busy_o = (cnt_q != 8'h00);
endmodule

/* pdm_ctrl.sv */
// power-down mode controller: sleep depths, halt, wake and clock gating
// What this block does
// RL1: control register bit 2 picks light or deep sleep for the sleep instruction.
// RL2: bit clear, sleep instruction enters light sleep.
// RL3: light sleep stops cpu; oscillator, interrupts, timer and tone keep running.
// RL4: registers, RAM and pins keep their state while powered down.
// RL5: light sleep ends on reset or interrupt request.
// RL6: bit set, sleep instruction enters deep sleep.
// RL7: deep sleep stops cpu; timer and tone run only from crystal clock.
// RL8: deep sleep wakes like light sleep, plus oscillator warm-up.
// RL9: halt instruction enters halt regardless of the depth bit.
// RL10: halt stops cpu; timer and tone run only from crystal clock.
// RL11: halt ends only on hardware reset, with warm-up after reset is released.
// RL12: masked interrupt still wakes sleep but skips the service routine.
// RL13: unmasked waking interrupt fetches its vector and runs the routine.
// RL14: rc core clock: deep sleep and halt stop timer, core clock, rc oscillator.
// RL15: crystal core clock: deep sleep and halt stop timer and core clock.
// RL16: masked wake resumes at the instruction after the sleep instruction.
`timescale 1ns/100ps
module pdm_ctrl (
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic [7:0] chip_control_register_i,
	input wire logic sleep_instruction_i,
	input wire logic halt_instr_i,
	input wire logic irq_i,
	input wire logic irq_mask_i,
	input wire logic core_clk_from_xtal_i,
	input wire logic timer_from_xtal_i,
	input wire logic tone_from_xtal_i,
	output pdm_pkg::pdm_gates_t gates_o,
	output pdm_pkg::pdm_wake_t wake_o,
	output pdm_pkg::pdm_state_t state_o,
	output logic warming_o
);
	import pdm_pkg::*;

	pdm_state_t state_q;
	pdm_state_t state_d;
	pdm_gates_t gates_d;
	pdm_gates_t gates_q;
	pdm_wake_t wake_q;
	logic irq_wake;
	logic warm_start;
	logic warm_busy;
	logic was_reset_q;
	logic [8:0] warm_seen_q;

	// interrupt only wakes the sleep states, never halt
	assign irq_wake = irq_i && (state_q == PDM_LIGHT || state_q == PDM_DEEP); // [RL5] [RL11]

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			PDM_RUN: begin
				if (halt_instr_i) begin
					state_d = PDM_HALT; // [RL9]
				end else if (sleep_instruction_i) begin
					if (chip_control_register_i[PDM_DEPTH_BIT]) begin // [RL1]
						state_d = PDM_DEEP; // [RL6]
					end else begin
						state_d = PDM_LIGHT; // [RL2]
					end
				end
			end
			PDM_LIGHT, PDM_DEEP: begin
				if (irq_i) begin
					state_d = PDM_RUN; // [RL5] [RL8]
				end
			end
			PDM_HALT: begin
				state_d = PDM_HALT; // [RL11]
			end
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= PDM_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// warm-up runs after reset and on leaving deep sleep
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			was_reset_q <= 1'b1;
		end else begin
			was_reset_q <= 1'b0;
		end
	end

	assign warm_start = was_reset_q || (state_q == PDM_DEEP && irq_i); // [RL8] [RL11]

	pdm_warmup u_warmup (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.start_i(warm_start),
		.busy_o(warm_busy)
	);

	// helper for the checks: cycles seen while warm-up is busy
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			warm_seen_q <= 9'h000;
		end else if (warm_start) begin
			warm_seen_q <= 9'h000;
		end else if (warm_busy) begin
			warm_seen_q <= warm_seen_q + 9'h001;
		end
	end

	always_comb begin
		gates_d = '1;
		unique case (state_d)
			PDM_RUN: begin
				gates_d.cpu_run = ~warm_start && ~warm_busy;
			end
			PDM_LIGHT: begin
				gates_d.cpu_run = 1'b0; // [RL3]
			end
			PDM_DEEP, PDM_HALT: begin
				gates_d.cpu_run = 1'b0; // [RL7] [RL10]
				gates_d.core_clock = 1'b0; // [RL14] [RL15]
				gates_d.event_timer_one = timer_from_xtal_i; // [RL7] [RL10] [RL14] [RL15]
				gates_d.tone_generator_unit = tone_from_xtal_i; // [RL7] [RL10]
				gates_d.rc_osc = core_clk_from_xtal_i; // [RL14] [RL15]
			end
		endcase
	end

	// gating only stops clocks; storage is never cleared here
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			gates_q <= '0;
		end else begin
			gates_q <= gates_d; // [RL4]
		end
	end

	// wake pulse: resume always, vector only when unmasked
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			wake_q <= '0;
		end else begin
			wake_q.resume <= irq_wake; // [RL16]
			wake_q.take_vector <= irq_wake && !irq_mask_i; // [RL12] [RL13]
		end
	end

	assign gates_o = gates_q;
	assign wake_o = wake_q;
	assign state_o = state_q;
	assign warming_o = warm_busy;

	property p_light_entry;
		@(posedge mclk_i) disable iff (rst_i)
		(state_q == PDM_RUN && sleep_instruction_i && !halt_instr_i
			&& !chip_control_register_i[PDM_DEPTH_BIT]) |=> state_q == PDM_LIGHT;
	endproperty
	a_light_entry: assert property (p_light_entry) else $error("light sleep not entered"); // [RL2]

	property p_deep_entry;
		@(posedge mclk_i) disable iff (rst_i)
		(state_q == PDM_RUN && sleep_instruction_i && !halt_instr_i
			&& chip_control_register_i[PDM_DEPTH_BIT]) |=> state_q == PDM_DEEP;
	endproperty
	a_deep_entry: assert property (p_deep_entry) else $error("deep sleep not entered"); // [RL6]

	property p_halt_entry;
		@(posedge mclk_i) disable iff (rst_i)
		(state_q == PDM_RUN && halt_instr_i) |=> state_q == PDM_HALT;
	endproperty
	a_halt_entry: assert property (p_halt_entry) else $error("halt not entered"); // [RL9]

	property p_halt_stays;
		@(posedge mclk_i) disable iff (rst_i)
		state_q == PDM_HALT |=> state_q == PDM_HALT;
	endproperty
	a_halt_stays: assert property (p_halt_stays) else $error("halt left without reset"); // [RL11]

	property p_light_gates;
		@(posedge mclk_i) disable iff (rst_i)
		state_q == PDM_LIGHT |-> !gates_o.cpu_run && gates_o.core_clock && gates_o.rc_osc
			&& gates_o.event_timer_one && gates_o.tone_generator_unit;
	endproperty
	a_light_gates: assert property (p_light_gates) else $error("light sleep gating wrong"); // [RL3]

	property p_deep_gates;
		@(posedge mclk_i) disable iff (rst_i)
		(state_q == PDM_DEEP || state_q == PDM_HALT) && $stable(state_q) |->
			!gates_o.core_clock && gates_o.rc_osc == $past(core_clk_from_xtal_i);
	endproperty
	a_deep_gates: assert property (p_deep_gates) else $error("deep gating wrong"); // [RL14]

	sequence s_sleep_irq;
		(state_q == PDM_LIGHT || state_q == PDM_DEEP) && irq_i;
	endsequence

	property p_wake_masked;
		@(posedge mclk_i) disable iff (rst_i)
		s_sleep_irq ##0 irq_mask_i |=> wake_o.resume && !wake_o.take_vector
			&& state_q == PDM_RUN;
	endproperty
	a_wake_masked: assert property (p_wake_masked) else $error("masked wake wrong"); // [RL12]

	property p_wake_vector;
		@(posedge mclk_i) disable iff (rst_i)
		s_sleep_irq ##0 !irq_mask_i |=> wake_o.take_vector;
	endproperty
	a_wake_vector: assert property (p_wake_vector) else $error("vector not taken"); // [RL13]

	sequence s_deep_wake;
		state_q == PDM_DEEP && irq_i;
	endsequence

	sequence s_light_wake;
		state_q == PDM_LIGHT && irq_i && !warming_o;
	endsequence

	property p_deep_warm;
		@(posedge mclk_i) disable iff (rst_i)
		s_deep_wake |=> warming_o [*2] ##1 !gates_o.cpu_run;
	endproperty
	a_deep_warm: assert property (p_deep_warm) else $error("no warm-up after deep"); // [RL8]

	property p_light_wake;
		@(posedge mclk_i) disable iff (rst_i)
		s_light_wake |=> !warming_o && gates_o.cpu_run;
	endproperty
	a_light_wake: assert property (p_light_wake) else $error("light wake not at once"); // [RL5]

	property p_reset_warm;
		@(posedge mclk_i) disable iff (rst_i)
		was_reset_q |=> warming_o && !gates_o.cpu_run;
	endproperty
	a_reset_warm: assert property (p_reset_warm) else $error("no warm-up after reset"); // [RL11]

	property p_warm_cpu;
		@(posedge mclk_i) disable iff (rst_i)
		warming_o |=> !gates_o.cpu_run;
	endproperty
	a_warm_cpu: assert property (p_warm_cpu) else $error("cpu runs during warm-up"); // [RL8]

	property p_warm_len;
		@(posedge mclk_i) disable iff (rst_i)
		$fell(warming_o) |-> warm_seen_q == 9'(PDM_WARMUP_CYC);
	endproperty
	a_warm_len: assert property (p_warm_len) else $error("warm-up length wrong"); // [RL11]

	property p_run_full;
		@(posedge mclk_i) disable iff (rst_i)
		state_q == PDM_RUN && !sleep_instruction_i && !halt_instr_i && !warm_start
			&& !warming_o |=> gates_o == '1;
	endproperty
	a_run_full: assert property (p_run_full) else $error("run gating wrong"); // [RL5]

	property p_xtal_runs;
		@(posedge mclk_i) disable iff (rst_i)
		!was_reset_q |-> gates_o.xtal_osc;
	endproperty
	a_xtal_runs: assert property (p_xtal_runs) else $error("crystal stopped"); // [RL15]

	property p_sleep_timer_tone;
		@(posedge mclk_i) disable iff (rst_i)
		(state_q == PDM_DEEP || state_q == PDM_HALT) && $stable(state_q) |->
			gates_o.event_timer_one == $past(timer_from_xtal_i)
			&& gates_o.tone_generator_unit == $past(tone_from_xtal_i);
	endproperty
	a_sleep_timer_tone: assert property (p_sleep_timer_tone) else $error("timer gate wrong"); // [RL7]

	property p_deep_stop;
		@(posedge mclk_i) disable iff (rst_i)
		state_q == PDM_DEEP |-> !gates_o.cpu_run && !gates_o.core_clock;
	endproperty
	a_deep_stop: assert property (p_deep_stop) else $error("deep sleep clocks run"); // [RL7]

	property p_halt_stop;
		@(posedge mclk_i) disable iff (rst_i)
		state_q == PDM_HALT |-> !gates_o.cpu_run && !gates_o.core_clock;
	endproperty
	a_halt_stop: assert property (p_halt_stop) else $error("halt clocks run"); // [RL10]

	property p_xtal_core;
		@(posedge mclk_i) disable iff (rst_i)
		(state_q == PDM_DEEP || state_q == PDM_HALT) && $stable(state_q)
			&& $past(core_clk_from_xtal_i) |-> gates_o.rc_osc && !gates_o.core_clock;
	endproperty
	a_xtal_core: assert property (p_xtal_core) else $error("crystal core gating wrong"); // [RL15]

	property p_sleep_holds;
		@(posedge mclk_i) disable iff (rst_i)
		(state_q == PDM_LIGHT || state_q == PDM_DEEP) && !irq_i |=> $stable(state_q);
	endproperty
	a_sleep_holds: assert property (p_sleep_holds) else $error("sleep left without irq"); // [RL5]

	property p_run_no_wake;
		@(posedge mclk_i) disable iff (rst_i)
		state_q == PDM_RUN |=> !wake_o.resume;
	endproperty
	a_run_no_wake: assert property (p_run_no_wake) else $error("wake while running"); // [RL5]

	property p_halt_no_wake;
		@(posedge mclk_i) disable iff (rst_i)
		state_q == PDM_HALT |=> !wake_o.resume && !wake_o.take_vector;
	endproperty
	a_halt_no_wake: assert property (p_halt_no_wake) else $error("wake from halt"); // [RL11]

	property p_vector_resume;
		@(posedge mclk_i) disable iff (rst_i)
		wake_o.take_vector |-> wake_o.resume;
	endproperty
	a_vector_resume: assert property (p_vector_resume) else $error("vector without wake"); // [RL13]
endmodule

/* pdm_cpu_model.sv */
// cpu core model: issues instructions and follows wake requests
`timescale 1ns/100ps
module pdm_cpu_model (
	input wire logic mclk_i,
	input wire logic rst_i,
	input pdm_pkg::pdm_wake_t wake_i,
	output logic sleep_o,
	output logic halt_o,
	output int isr_cnt_o,
	output int next_cnt_o
);
	import pdm_pkg::*;
	initial begin
		sleep_o = 1'b0;
		halt_o = 1'b0;
	end
	task automatic exec(input logic s, input logic h);
		@(posedge mclk_i);
		#1;
		sleep_o = s;
		halt_o = h;
		@(posedge mclk_i);
		#1;
		sleep_o = 1'b0;
		halt_o = 1'b0;
	endtask
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			isr_cnt_o <= 0;
			next_cnt_o <= 0;
		end else if (wake_i.resume) begin
			if (wake_i.take_vector) isr_cnt_o <= isr_cnt_o + 1;
			else next_cnt_o <= next_cnt_o + 1;
		end
	end
endmodule

/* tb.sv */
// testbench for the power-down mode controller
`timescale 1ns/100ps
module tb;
	import pdm_pkg::*;
	logic mclk_i, rst_i, irq, msk, cx, tx, px, sl, hl, warm;
	logic [7:0] ctrl;
	pdm_gates_t g;
	pdm_wake_t wk;
	pdm_state_t st, es;
	int isr, nxt, i0, n0, errors, check_count, seed, n, k;
	pdm_ctrl dut (.mclk_i(mclk_i), .rst_i(rst_i), .chip_control_register_i(ctrl),
		.sleep_instruction_i(sl), .halt_instr_i(hl), .irq_i(irq), .irq_mask_i(msk),
		.core_clk_from_xtal_i(cx), .timer_from_xtal_i(tx), .tone_from_xtal_i(px),
		.gates_o(g), .wake_o(wk), .state_o(st), .warming_o(warm));
	pdm_cpu_model cpu (.mclk_i(mclk_i), .rst_i(rst_i), .wake_i(wk), .sleep_o(sl),
		.halt_o(hl), .isr_cnt_o(isr), .next_cnt_o(nxt));
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	function automatic logic [7:0] exp_g(pdm_state_t s);
		if (s == PDM_RUN) return 8'h3F;
		if (s == PDM_LIGHT) return 8'h1F;
		return {4'h0, cx, 1'b1, tx, px};
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] v);
		check_count++;
		if (v !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, v);
		end
	endtask
	task automatic chk_s(input pdm_state_t e);
		chk("state", 8'(e), 8'(st));
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic warm_up(input logic on);
		n = 0;
		while (warm === 1'b1 && n < 400) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		if (n >= 400) begin
			errors++;
			stop_test();
		end
		// cpu enable is registered, so it rises one cycle after warm-up clears
		@(posedge mclk_i);
		#1;
		if (on) chk("warm_len", 8'(n >= PDM_WARMUP_CYC - 2 && n <= PDM_WARMUP_CYC), 8'h01);
		chk("run_gates", 8'h3F, 8'(g));
	endtask
	task automatic do_reset;
		rst_i = 1'b1;
		repeat (10) @(posedge mclk_i);
		#1;
		chk("rst_gates", 8'h00, 8'(g));
		rst_i = 1'b0;
		@(posedge mclk_i);
		#1;
		warm_up(1'b1);
	endtask
	initial begin
		{irq, msk, cx, tx, px, errors, check_count} = '0;
		ctrl = PDM_CTRL_RESET;
		seed = 32'h4ab2;
		do_reset();
		for (int i = 0; i < 24; i++) begin
			irq = 1'b1;
			@(posedge mclk_i);
			#1;
			irq = 1'b0;
			chk_s(PDM_RUN);
			chk("run_irq", 8'h00, 8'(wk));
			k = (i < 4) ? i : $unsigned($random(seed)) % 4;
			ctrl = 8'($random(seed));
			if (k < 2) ctrl[PDM_DEPTH_BIT] = k[0];
			{cx, tx, px, msk} = 4'($random(seed));
			es = (k == 0) ? PDM_LIGHT : (k == 1) ? PDM_DEEP : PDM_HALT;
			cpu.exec(k != 2, k >= 2);
			chk_s(es);
			chk("gates", exp_g(es), 8'(g));
			cpu.exec(k != 0, k == 0);
			chk_s(es);
			{i0, n0} = {isr, nxt};
			irq = 1'b1;
			@(posedge mclk_i);
			#1;
			irq = 1'b0;
			if (es == PDM_HALT) begin
				chk_s(PDM_HALT);
				chk("wake", 8'h00, 8'(wk));
				do_reset();
			end else begin
				chk_s(PDM_RUN);
				chk("wake", {6'h00, 1'b1, ~msk}, 8'(wk));
				chk("warming", 8'(es == PDM_DEEP), 8'(warm));
				chk("wake_gates", (es == PDM_DEEP) ? 8'h1F : 8'h3F, 8'(g));
				warm_up(es == PDM_DEEP);
				@(posedge mclk_i);
				#1;
				chk("vector", 8'(!msk), 8'(isr - i0));
				chk("next", 8'(msk), 8'(nxt - n0));
			end
		end
		stop_test();
	end
endmodule
